//--- src/csf_status.sv
`timescale 1ns/1ps
`default_nettype none
`include "csf_params.svh"

// Overview of operation
// - separate overflow flag per accumulator, last result
// - accumulator a saturation flag stays set
// - accumulator b saturation flag stays set
// - combined overflow is or of both, clearable
// - combined saturation is or of both, clearable
// - writes set saturation flags, zero combined clears
// - do loop indicator follows loop, read only
// - digit carry out of bit three or seven
// - low priority bits joined with top bit
// - low priority bits locked while nesting blocked
// - repeat indicator follows repeat loop, read only
// - zero flag only changed by zero affecting ops and status word writes
// - signed overflow on sign flipping magnitude overflow
module csf_status (
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // accumulator results
  input wire logic acc_a_upd_i,
  input wire logic acc_a_ovf_i,
  input wire logic acc_a_sat_i,
  input wire logic acc_b_upd_i,
  input wire logic acc_b_ovf_i,
  input wire logic acc_b_sat_i,
  // loop state from the sequencer
  input wire logic loop_block_running_i,
  input wire logic repeat_running_i,
  // alu operation
  input wire logic alu_upd_i,
  input wire logic alu_z_aff_i,
  input wire logic alu_byte_i,
  input wire logic alu_sub_i,
  input wire logic alu_cin_i,
  input wire logic [15:0] alu_opa_i,
  input wire logic [15:0] alu_opb_i,
  // priority control from the core and interrupt control words
  input wire logic cpu_priority_top_bit_i,
  input wire logic nesting_block_bit_i,
  // results
  output logic [15:0] cpu_status_word_o,
  output logic [3:0] cpu_priority_o,
  output logic user_irq_block_o,
  output logic irq_o
);

  // ****************************************************************
  // decode and flag storage
  // ****************************************************************

  // address match, used by every register strobe
  function automatic logic csf_hit(input logic [3:0] a, input logic [3:0] o);
    csf_hit = (a == o);
  endfunction : csf_hit

  logic st_wr; // software write of the status word
  logic st_rd; // software read of the status word
  logic is_rd; // read of the event status register
  logic mk_wr; // write of the mask register

  logic acc_a_wrap_flag_q; // accumulator a overflow
  logic acc_b_wrap_flag_q; // accumulator b overflow
  logic acc_a_clip_sticky_q; // accumulator a saturated
  logic acc_b_clip_sticky_q; // accumulator b saturated
  logic loop_block_running_q; // do loop active
  logic nibble_carry_flag_q; // digit carry
  logic [2:0] cpu_priority_low_bits_q; // low priority bits
  logic repeat_running_q; // repeat active
  logic neg_flag_q; // negative
  logic signed_range_exceeded_flag_q; // signed overflow
  logic zero_flag_q; // zero
  logic carry_flag_q; // carry
  logic either_acc_wrap_flag; // combined overflow
  logic either_acc_clip_flag; // combined saturation

  logic [3:0] evt_stat_q; // sticky event bits
  logic [3:0] evt_mask_q; // event enables
  logic [3:0] evt_set; // events of this cycle
  logic [15:0] rdata_q; // read data register

  logic alu_c; // carry from the flag unit
  logic alu_dc; // digit carry from the flag unit
  logic alu_ov; // signed overflow from the flag unit
  logic alu_n; // negative from the flag unit
  logic alu_z; // zero result from the flag unit

  assign st_wr = wr_i && csf_hit(addr_i, `CSF_OFF_STATUS);
  assign st_rd = rd_i && csf_hit(addr_i, `CSF_OFF_STATUS);
  assign is_rd = rd_i && csf_hit(addr_i, `CSF_OFF_ISTAT);
  assign mk_wr = wr_i && csf_hit(addr_i, `CSF_OFF_IMASK);

  // ****************************************************************
  // alu result flags
  // ****************************************************************

  // flag computation for the current operation
  csf_alu_flags u_alu_flags (
    .opa_i(alu_opa_i),
    .opb_i(alu_opb_i),
    .carry_in_i(alu_cin_i),
    .sub_i(alu_sub_i),
    .byte_i(alu_byte_i),
    .carry_o(alu_c),
    .nibble_carry_o(alu_dc),
    .signed_ovf_o(alu_ov),
    .neg_o(alu_n),
    .zero_o(alu_z)
  );

  // carry, digit carry, negative and signed overflow per operation
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      carry_flag_q <= 1'b0;
      nibble_carry_flag_q <= 1'b0;
      neg_flag_q <= 1'b0;
      signed_range_exceeded_flag_q <= 1'b0;
    end else if (alu_upd_i) begin
      // operation result wins over a write in the same cycle
      carry_flag_q <= alu_c;
      nibble_carry_flag_q <= alu_dc;
      neg_flag_q <= alu_n;
      signed_range_exceeded_flag_q <= alu_ov;
    end else if (st_wr) begin
      carry_flag_q <= wdata_i[`CSF_B_C];
      nibble_carry_flag_q <= wdata_i[`CSF_B_DC];
      neg_flag_q <= wdata_i[`CSF_B_N];
      signed_range_exceeded_flag_q <= wdata_i[`CSF_B_OV];
    end
  end

  // zero flag only moves on operations that affect it and on status word writes
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      zero_flag_q <= 1'b0;
    end else if (alu_upd_i && alu_z_aff_i) begin
      zero_flag_q <= alu_z;
    end else if (st_wr) begin
      zero_flag_q <= wdata_i[`CSF_B_Z];
    end
  end

  // ****************************************************************
  // accumulator flags
  // ****************************************************************

  // overflow flags follow the latest result of each accumulator
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_a_wrap_flag_q <= 1'b0;
      acc_b_wrap_flag_q <= 1'b0;
    end else begin
      if (acc_a_upd_i) begin
        acc_a_wrap_flag_q <= acc_a_ovf_i;
      end else if (st_wr) begin
        // zero in the combined bit clears, else plain write
        acc_a_wrap_flag_q <= wdata_i[`CSF_B_OA] & wdata_i[`CSF_B_OAB];
      end
      if (acc_b_upd_i) begin
        acc_b_wrap_flag_q <= acc_b_ovf_i;
      end else if (st_wr) begin
        acc_b_wrap_flag_q <= wdata_i[`CSF_B_OB] & wdata_i[`CSF_B_OAB];
      end
    end
  end

  // sticky saturation: a saturation event wins over any write
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_a_clip_sticky_q <= 1'b0;
      acc_b_clip_sticky_q <= 1'b0;
    end else begin
      if (acc_a_sat_i) begin
        acc_a_clip_sticky_q <= 1'b1;
      end else if (st_wr) begin
        // direct write, or clear through the combined bit
        acc_a_clip_sticky_q <= wdata_i[`CSF_B_SA] & wdata_i[`CSF_B_SAB];
      end
      if (acc_b_sat_i) begin
        acc_b_clip_sticky_q <= 1'b1;
      end else if (st_wr) begin
        acc_b_clip_sticky_q <= wdata_i[`CSF_B_SB] & wdata_i[`CSF_B_SAB];
      end
    end
  end

  // combined flags are kept equal to the or of their parts
  assign either_acc_wrap_flag = acc_a_wrap_flag_q |
                                acc_b_wrap_flag_q;
  assign either_acc_clip_flag = acc_a_clip_sticky_q |
                                acc_b_clip_sticky_q;

  // ****************************************************************
  // loop indicators and priority level
  // ****************************************************************

  // read only loop indicators, writes are ignored
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      loop_block_running_q <= 1'b0;
      repeat_running_q <= 1'b0;
    end else begin
      loop_block_running_q <= loop_block_running_i;
      repeat_running_q <= repeat_running_i;
    end
  end

  // low priority bits, writable unless nesting is blocked
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cpu_priority_low_bits_q <= `CSF_IPL_RST;
    end else if (st_wr && !nesting_block_bit_i) begin
      cpu_priority_low_bits_q <= wdata_i[`CSF_B_IPL_HI:`CSF_B_IPL_LO];
    end
  end

  // full level and the user interrupt block
  assign cpu_priority_o = {cpu_priority_top_bit_i,
                           cpu_priority_low_bits_q};
  assign user_irq_block_o = cpu_priority_top_bit_i ||
                            (cpu_priority_low_bits_q == `CSF_IPL_MAX);

  // status word image, every bit straight from a flop except the two combined flags, which are ors of flops
  assign cpu_status_word_o = {acc_a_wrap_flag_q, acc_b_wrap_flag_q,
                              acc_a_clip_sticky_q, acc_b_clip_sticky_q,
                              either_acc_wrap_flag, either_acc_clip_flag,
                              loop_block_running_q, nibble_carry_flag_q,
                              cpu_priority_low_bits_q, repeat_running_q,
                              neg_flag_q, signed_range_exceeded_flag_q,
                              zero_flag_q, carry_flag_q};

  // ****************************************************************
  // interrupt events
  // ****************************************************************

  // events of this cycle in event slot order
  always_comb begin
    evt_set = `CSF_IRQ_RST;
    evt_set[csf_pkg::csf_evt_clip_a] = acc_a_sat_i;
    evt_set[csf_pkg::csf_evt_clip_b] = acc_b_sat_i;
    evt_set[csf_pkg::csf_evt_wrap] = (acc_a_upd_i && acc_a_ovf_i) ||
                                     (acc_b_upd_i && acc_b_ovf_i);
    evt_set[csf_pkg::csf_evt_signed] = alu_upd_i && alu_ov;
  end

  // sticky bits, cleared by reading, a new event wins over the read
  for (genvar gi = 0; gi < `CSF_IRQ_N; gi++) begin : g_evt
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        evt_stat_q[gi] <= 1'b0;
      end else if (evt_set[gi]) begin
        evt_stat_q[gi] <= 1'b1;
      end else if (is_rd) begin
        evt_stat_q[gi] <= 1'b0;
      end
    end
  end

  // mask register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      evt_mask_q <= `CSF_IRQ_RST;
    end else if (mk_wr) begin
      evt_mask_q <= wdata_i[3:0];
    end
  end

  // level interrupt while any enabled event is pending
  assign irq_o = |(evt_stat_q & evt_mask_q);

  // ****************************************************************
  // read port
  // ****************************************************************

  // read data stand in the cycle after the strobe only
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= `CSF_STATUS_RST;
    end else if (st_rd) begin
      rdata_q <= cpu_status_word_o;
    end else if (is_rd) begin
      rdata_q <= {12'h000, evt_stat_q};
    end else if (rd_i && csf_hit(addr_i, `CSF_OFF_IMASK)) begin
      rdata_q <= {12'h000, evt_mask_q};
    end else begin
      // unmapped reads and idle cycles give zero
      rdata_q <= 16'h0000;
    end
  end

  assign rdata_o = rdata_q;

  // ****************************************************************
  // assertions
  // ****************************************************************

  default clocking csf_cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  acc_a_wrap_a: assert property (
    acc_a_upd_i |=> acc_a_wrap_flag_q == $past(acc_a_ovf_i))
    else $error("accumulator a overflow flag wrong");
  clip_a_hold_a: assert property (
    acc_a_clip_sticky_q && !st_wr |=> acc_a_clip_sticky_q [*1])
    else $error("accumulator a saturation flag lost");
  clip_b_set_a: assert property (
    acc_b_sat_i |=> acc_b_clip_sticky_q && cpu_status_word_o[`CSF_B_SB])
    else $error("accumulator b saturation flag not set");
  wrap_or_a: assert property (
    acc_b_upd_i && acc_b_ovf_i |=> cpu_status_word_o[`CSF_B_OAB])
    else $error("combined overflow not set");
  clip_or_a: assert property (
    acc_a_sat_i |=> cpu_status_word_o[`CSF_B_SAB])
    else $error("combined saturation not set");
  clip_clear_a: assert property (
    st_wr && !wdata_i[`CSF_B_SAB] && !acc_a_sat_i && !acc_b_sat_i |=>
    !acc_a_clip_sticky_q && !acc_b_clip_sticky_q)
    else $error("combined clear left saturation set");
  loop_run_a: assert property (
    loop_block_running_i |=> cpu_status_word_o[`CSF_B_DA])
    else $error("loop indicator not following loop");
  nibble_carry_a: assert property (
    alu_upd_i |=> nibble_carry_flag_q == $past(alu_dc))
    else $error("digit carry not taken");
  prio_join_a: assert property (
    cpu_priority_top_bit_i |-> user_irq_block_o && cpu_priority_o[3])
    else $error("top priority bit not blocking");
  prio_lock_a: assert property (
    nesting_block_bit_i |=> $stable(cpu_priority_low_bits_q))
    else $error("priority bits changed while locked");
  repeat_run_a: assert property (
    !repeat_running_i |=> !cpu_status_word_o[`CSF_B_RA])
    else $error("repeat indicator stuck");
  zero_keep_a: assert property (
    !alu_z_aff_i && !st_wr |=> $stable(zero_flag_q))
    else $error("zero flag moved without cause");
  signed_ov_a: assert property (
    alu_upd_i && alu_ov |=> cpu_status_word_o[`CSF_B_OV])
    else $error("signed overflow not flagged");
  reset_zero_a: assert property (
    @(posedge clk_i) disable iff (1'b0)
    $past(rst_i) |-> cpu_status_word_o == `CSF_STATUS_RST)
    else $error("status word not zero after reset");
  irq_level_a: assert property (
    acc_a_sat_i && evt_mask_q[0] && !mk_wr |=> irq_o)
    else $error("interrupt not raised");

  sat_then_clear_c: cover property (
    acc_a_sat_i ##1 st_wr && !wdata_i[`CSF_B_SAB]);
  both_wrap_c: cover property (
    acc_a_upd_i && acc_a_ovf_i && acc_b_upd_i && acc_b_ovf_i);
  locked_write_c: cover property (st_wr && nesting_block_bit_i);
  read_race_c: cover property (is_rd && |evt_set);

endmodule : csf_status

`default_nettype wire

//--- src/csf_params.svh
`ifndef CSF_PARAMS_SVH
`define CSF_PARAMS_SVH

// ****************************************************************
// register map (byte addresses on the plain register port)
// ****************************************************************
`define CSF_ADDR_W 4
`define CSF_DATA_W 16
`define CSF_OFF_STATUS 4'h0
`define CSF_OFF_ISTAT 4'h2
`define CSF_OFF_IMASK 4'h4

// ****************************************************************
// status word field positions
// ****************************************************************
`define CSF_B_OA 15
`define CSF_B_OB 14
`define CSF_B_SA 13
`define CSF_B_SB 12
`define CSF_B_OAB 11
`define CSF_B_SAB 10
`define CSF_B_DA 9
`define CSF_B_DC 8
`define CSF_B_IPL_HI 7
`define CSF_B_IPL_LO 5
`define CSF_B_RA 4
`define CSF_B_N 3
`define CSF_B_OV 2
`define CSF_B_Z 1
`define CSF_B_C 0

// ****************************************************************
// reset values and sizes
// ****************************************************************
`define CSF_STATUS_RST 16'h0000
`define CSF_IRQ_N 4
`define CSF_IRQ_RST 4'h0
`define CSF_IPL_RST 3'h0
`define CSF_IPL_MAX 3'h7

`endif

//--- src/csf_pkg.sv
// ****************************************************************
// shared types of the status flag block
// ****************************************************************
package csf_pkg;

  // one status word
  typedef logic [15:0] csf_word_t;

  // interrupt event slots in the event status register
  typedef enum logic [1:0] {
    csf_evt_clip_a = 2'h0,
    csf_evt_clip_b = 2'h1,
    csf_evt_wrap = 2'h2,
    csf_evt_signed = 2'h3
  } csf_evt_t;

endpackage : csf_pkg

//--- src/csf_alu_flags.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// result flags of one add or subtract, byte or word sized
// ****************************************************************
module csf_alu_flags (
  input wire logic [15:0] opa_i,
  input wire logic [15:0] opb_i,
  input wire logic carry_in_i,
  input wire logic sub_i,
  input wire logic byte_i,
  output logic carry_o,
  output logic nibble_carry_o,
  output logic signed_ovf_o,
  output logic neg_o,
  output logic zero_o
);

  logic [15:0] opb_eff; // second operand, inverted for subtract
  logic [4:0] sum4; // low nibble sum with carry out
  logic [8:0] sum8; // low byte sum with carry out
  logic [16:0] sum16; // full word sum with carry out
  logic sa; // sign of operand a
  logic sb; // sign of effective operand b
  logic sr; // sign of result

  // subtract is a plus not b plus carry in, carry means no borrow
  always_comb begin
    opb_eff = sub_i ? ~opb_i : opb_i;
    sum4 = {1'b0, opa_i[3:0]} + {1'b0, opb_eff[3:0]} + {4'h0, carry_in_i};
    sum8 = {1'b0, opa_i[7:0]} + {1'b0, opb_eff[7:0]} + {8'h00, carry_in_i};
    sum16 = {1'b0, opa_i} + {1'b0, opb_eff} + {16'h0000, carry_in_i};
    // byte ops: digit carry from bit 3, word ops: from bit 7
    nibble_carry_o = byte_i ? sum4[4] : sum8[8];
    carry_o = byte_i ? sum8[8] : sum16[16];
    sa = byte_i ? opa_i[7] : opa_i[15];
    sb = byte_i ? opb_eff[7] : opb_eff[15];
    sr = byte_i ? sum8[7] : sum16[15];
    // sign change caused by magnitude overflow
    signed_ovf_o = (sa == sb) && (sr != sa);
    neg_o = sr;
    zero_o = byte_i ? (sum8[7:0] == 8'h00) : (sum16[15:0] == 16'h0000);
  end

endmodule : csf_alu_flags

`default_nettype wire

//--- verif/csf_exec_model.sv
`timescale 1ns/1ps
`default_nettype none

// ********************
// execution unit stand-in: result strobes and loop levels
// ********************
module csf_exec_model (
  input wire logic clk_i,
  output logic acc_a_upd_o,
  output logic acc_a_ovf_o,
  output logic acc_a_sat_o,
  output logic acc_b_upd_o,
  output logic acc_b_ovf_o,
  output logic acc_b_sat_o,
  output logic loop_block_running_o,
  output logic repeat_running_o,
  output logic alu_upd_o,
  output logic alu_z_aff_o,
  output logic alu_byte_o,
  output logic alu_sub_o,
  output logic alu_cin_o,
  output logic [15:0] alu_opa_o,
  output logic [15:0] alu_opb_o
);
  // everything idle from time zero
  initial begin
    {acc_a_upd_o, acc_a_ovf_o, acc_a_sat_o} = 3'h0;
    {acc_b_upd_o, acc_b_ovf_o, acc_b_sat_o} = 3'h0;
    {loop_block_running_o, repeat_running_o} = 2'h0;
    {alu_upd_o, alu_z_aff_o, alu_byte_o, alu_sub_o, alu_cin_o} = 5'h0;
    alu_opa_o = 16'h0000;
    alu_opb_o = 16'h0000;
  end

  // one accumulator result {upd, ovf, sat}, one cycle long
  task automatic acc_op(input logic sel_b, input logic [2:0] uos);
    @(posedge clk_i);
    {acc_a_upd_o, acc_a_ovf_o, acc_a_sat_o} <= sel_b ? 3'h0 : uos;
    {acc_b_upd_o, acc_b_ovf_o, acc_b_sat_o} <= sel_b ? uos : 3'h0;
    @(posedge clk_i);
    {acc_a_upd_o, acc_a_ovf_o, acc_a_sat_o} <= 3'h0;
    {acc_b_upd_o, acc_b_ovf_o, acc_b_sat_o} <= 3'h0;
  endtask : acc_op

  // loop levels change after an edge and then stay
  task automatic loops(input logic do_run, input logic rep_run);
    @(posedge clk_i);
    loop_block_running_o <= do_run;
    repeat_running_o <= rep_run;
  endtask : loops

  // one alu op; zbsc is {z_aff, byte, sub, cin}
  task automatic alu_op(input logic [3:0] zbsc, input logic [15:0] a,
                        input logic [15:0] b);
    @(posedge clk_i);
    alu_upd_o <= 1'b1;
    {alu_z_aff_o, alu_byte_o, alu_sub_o, alu_cin_o} <= zbsc;
    alu_opa_o <= a;
    alu_opb_o <= b;
    @(posedge clk_i);
    alu_upd_o <= 1'b0;
    alu_z_aff_o <= 1'b0;
    // released operands do not keep their old value
    alu_opa_o <= ~a;
    alu_opb_o <= ~b;
  endtask : alu_op
endmodule : csf_exec_model

`default_nettype wire

//--- verif/test_cpu_status_flags.sv
`timescale 1ns/1ps
`default_nettype none

module test_cpu_status_flags;
  // ********************
  // stimulus and observed nets
  // ********************
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic top_i = 1'b0;
  logic nest_i = 1'b0;
  logic a_upd, a_ovf, a_sat, b_upd, b_ovf, b_sat, do_run, rep_run;
  logic alu_upd, z_aff, alu_byte, alu_sub, alu_cin;
  logic [15:0] opa, opb, rdata_o, word_o;
  logic [3:0] prio_o;
  logic block_o, irq_o;
  int err_total = 0;
  int checks = 0;

  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;

  csf_exec_model mdl (.clk_i(clk_i), .acc_a_upd_o(a_upd),
    .acc_a_ovf_o(a_ovf), .acc_a_sat_o(a_sat), .acc_b_upd_o(b_upd),
    .acc_b_ovf_o(b_ovf), .acc_b_sat_o(b_sat),
    .loop_block_running_o(do_run), .repeat_running_o(rep_run),
    .alu_upd_o(alu_upd), .alu_z_aff_o(z_aff), .alu_byte_o(alu_byte),
    .alu_sub_o(alu_sub), .alu_cin_o(alu_cin), .alu_opa_o(opa),
    .alu_opb_o(opb));

  csf_status uut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .acc_a_upd_i(a_upd), .acc_a_ovf_i(a_ovf), .acc_a_sat_i(a_sat),
    .acc_b_upd_i(b_upd), .acc_b_ovf_i(b_ovf), .acc_b_sat_i(b_sat),
    .loop_block_running_i(do_run), .repeat_running_i(rep_run),
    .alu_upd_i(alu_upd), .alu_z_aff_i(z_aff), .alu_byte_i(alu_byte),
    .alu_sub_i(alu_sub), .alu_cin_i(alu_cin), .alu_opa_i(opa),
    .alu_opb_i(opb), .cpu_priority_top_bit_i(top_i),
    .nesting_block_bit_i(nest_i), .cpu_status_word_o(word_o),
    .cpu_priority_o(prio_o), .user_irq_block_o(block_o), .irq_o(irq_o));

  // ********************
  // shared tasks
  // ********************
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
      err_total++;
    end
  endtask : cmp

  // status word after the edge that took the last request
  task automatic st(input logic [15:0] exp);
    @(negedge clk_i);
    cmp(word_o, exp);
  endtask : st

  task automatic irq_is(input logic exp);
    @(negedge clk_i);
    cmp({15'h0, irq_o}, {15'h0, exp});
  endtask : irq_is

  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  // read data stand one cycle only, then fall back to zero
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    cmp(rdata_o, exp);
    @(negedge clk_i);
    cmp(rdata_o, 16'h0000);
  endtask : rd

  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    st(16'h0000);
    cmp({12'h0, prio_o}, 16'h0000);
    cmp({15'h0, irq_o}, 16'h0000);
  endtask : do_reset

  // ********************
  // scenarios
  // ********************
  task automatic alu_tests();
    wr(4'h0, 16'h0000);
    mdl.alu_op(4'hc, 16'h000f, 16'h0001);
    st(16'h0100);
    mdl.alu_op(4'h8, 16'h00ff, 16'h0001);
    st(16'h0100);
    mdl.alu_op(4'h8, 16'h000f, 16'h0001);
    st(16'h0000);
    mdl.alu_op(4'h8, 16'hffff, 16'h0001);
    st(16'h0103);
    mdl.alu_op(4'h0, 16'h0001, 16'h0001);
    st(16'h0002);
    mdl.alu_op(4'h8, 16'h7fff, 16'h0001);
    st(16'h010c);
    mdl.alu_op(4'h3, 16'h0000, 16'h0001);
    st(16'h0008);
  endtask : alu_tests

  task automatic acc_tests();
    wr(4'h0, 16'h0000);
    mdl.acc_op(1'b0, 3'h6);
    st(16'h8800);
    mdl.acc_op(1'b1, 3'h6);
    st(16'hc800);
    mdl.acc_op(1'b0, 3'h4);
    st(16'h4800);
    mdl.acc_op(1'b0, 3'h6);
    // zero in the combined bit clears both overflow flags
    wr(4'h0, 16'hc000);
    st(16'h0000);
  endtask : acc_tests

  // whole-word writes only, never bit operations on the sticky pair
  task automatic sat_tests();
    mdl.acc_op(1'b0, 3'h1);
    st(16'h2400);
    repeat (4) @(posedge clk_i);
    st(16'h2400);
    mdl.acc_op(1'b1, 3'h1);
    st(16'h3400);
    wr(4'h0, 16'h3400);
    st(16'h3400);
    wr(4'h0, 16'h3000);
    st(16'h0000);
    wr(4'h0, 16'h1400);
    st(16'h1400);
    cmp({15'h0, irq_o}, 16'h0000);
  endtask : sat_tests

  task automatic loop_tests();
    wr(4'h0, 16'h0000);
    mdl.loops(1'b1, 1'b0);
    @(posedge clk_i);
    st(16'h0200);
    wr(4'h0, 16'h0010);
    st(16'h0200);
    mdl.loops(1'b0, 1'b1);
    @(posedge clk_i);
    st(16'h0010);
    mdl.loops(1'b0, 1'b0);
    @(posedge clk_i);
    st(16'h0000);
  endtask : loop_tests

  task automatic ipl_tests();
    wr(4'h0, 16'h00a0);
    st(16'h00a0);
    cmp({12'h0, prio_o}, 16'h0005);
    cmp({15'h0, block_o}, 16'h0000);
    @(posedge clk_i);
    top_i <= 1'b1;
    @(negedge clk_i);
    cmp({12'h0, prio_o}, 16'h000d);
    cmp({15'h0, block_o}, 16'h0001);
    @(posedge clk_i);
    top_i <= 1'b0;
    wr(4'h0, 16'h00e0);
    st(16'h00e0);
    cmp({15'h0, block_o}, 16'h0001);
    @(posedge clk_i);
    nest_i <= 1'b1;
    wr(4'h0, 16'h0020);
    st(16'h00e0);
    @(posedge clk_i);
    nest_i <= 1'b0;
    wr(4'h0, 16'h0020);
    st(16'h0020);
  endtask : ipl_tests

  task automatic irq_tests();
    // sticky events left by the earlier scenarios, then cleared
    rd(4'h2, 16'h000f);
    rd(4'h2, 16'h0000);
    wr(4'h4, 16'hffff);
    rd(4'h4, 16'h000f);
    wr(4'h4, 16'h0001);
    mdl.acc_op(1'b1, 3'h1);
    irq_is(1'b0);
    mdl.acc_op(1'b0, 3'h1);
    irq_is(1'b1);
    rd(4'h2, 16'h0003);
    irq_is(1'b0);
    // event status is not writable; unmapped reads give zero
    wr(4'h2, 16'h000f);
    rd(4'h2, 16'h0000);
    rd(4'h6, 16'h0000);
    mdl.acc_op(1'b0, 3'h1);
    do_reset();
  endtask : irq_tests

  task automatic results();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  // main sequence
  initial begin
    do_reset();
    alu_tests();
    acc_tests();
    sat_tests();
    loop_tests();
    ipl_tests();
    irq_tests();
    results();
  end

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    err_total++;
    results();
  end
endmodule : test_cpu_status_flags

`default_nettype wire
